// ===== rtl/amt_pkg.sv
// Package: register map, field layout, timing and carrier types
package amt_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_ALERT_MASK_ONE = 8'h74;
  localparam logic [7:0] IDX_ALERT_MASK_TWO = 8'h75;
  localparam logic [7:0] IDX_VOLTAGE_LOW_BITS = 8'h76;
  localparam logic [7:0] IDX_TEMPERATURE_LOW_BITS = 8'h77;
  localparam logic [7:0] IDX_PIN_AND_SPEED_CONFIG = 8'h78;
  localparam logic [7:0] IDX_OVERHEAT_DURATION_STATUS = 8'h79;
  localparam logic [7:0] IDX_ASSERT_DURATION_LIMIT = 8'h7a;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'h80;
  localparam logic [7:0] IDX_EVENT_CLEAR = 8'h81;
  localparam logic [7:0] IDX_EVENT_ENABLE = 8'h82;
  localparam logic [7:0] IDX_HIGH_BYTE_BASE = 8'h83;
  localparam int NUM_READINGS = 5;

  // ---------------------------------------------------------------
  // Reset values and field positions
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_MASK = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_LIMIT = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam int BIT_FAN_ONE = 2;
  localparam int BIT_FAN_FOUR_OR_TIMER = 5;
  localparam int BIT_DIODE_ONE = 6;
  localparam logic [7:0] MASK_TWO_WRITABLE = 8'hfd;
  localparam logic [7:0] ALERT_SOURCES = 8'hfc;
  localparam logic [7:0] VOLT_RSV_BITS = 8'hcc;
  localparam logic [7:0] TEMP_RSV_BITS = 8'h03;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int TICK_PERIOD_US = 22760;
  localparam int TICK_CYCLES = TICK_PERIOD_US * CLK_MHZ;
  localparam int REPORT_START_US = 45520;
  localparam logic [7:0] REPORT_START_TICKS =
    8'(REPORT_START_US / TICK_PERIOD_US);
  localparam logic [7:0] COUNT_FULL = 8'hff;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic continuous_speed_four;
    logic continuous_speed_three;
    logic continuous_speed_two;
    logic continuous_speed_one;
    logic fast_speed_rate;
    logic full_speed_on_overheat;
    logic overheat_monitor_en;
    logic alert_pin_sel;
  } amt_cfg_t;

  typedef struct packed {
    logic [9:0] remote_two;
    logic [9:0] local_temp;
    logic [9:0] remote_one;
    logic [9:0] supply;
    logic [9:0] ref_two_five;
  } amt_meas_t;
endpackage

// ===== rtl/amt_overheat_timer.sv
// Overheat assertion duration timer with status and limit event
`timescale 1ns/1ps
module amt_overheat_timer #(
  parameter int TICK_CYC = amt_pkg::TICK_CYCLES
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Control
  input wire logic monitor_en,
  input wire logic overheat_active,
  input wire logic [7:0] duration_limit,
  input wire logic status_read,
  // Results
  output logic [7:0] status_q,
  output logic timer_event_q
);
  // ---------------------------------------------------------------
  // Edge detect and prescaler
  // ---------------------------------------------------------------
  logic act;
  logic prev_q;
  logic rise;
  logic tick;
  logic flagged_q;
  logic [31:0] presc_q;
  logic [7:0] dur_q;

  assign act = monitor_en & overheat_active;
  assign rise = act & ~prev_q;
  assign tick = act & prev_q & (presc_q == 32'(TICK_CYC - 1));

  // Input history for the assertion edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
    end else if (ce) begin
      prev_q <= act;
    end
  end

  // Tick prescaler restarts with each assertion
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_q <= 32'h0;
    end else if (ce) begin
      if (rise || tick || !act) begin
        presc_q <= 32'h0;
      end else begin
        presc_q <= presc_q + 32'h1;
      end
    end
  end

  // Duration in ticks, holds at full scale instead of wrapping
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dur_q <= 8'h00;
    end else if (ce) begin
      if (rise) begin
        dur_q <= 8'h00;
      end else if (tick && dur_q != amt_pkg::COUNT_FULL) begin
        dur_q <= dur_q + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // Status register: flag first, count once past the start time
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q <= amt_pkg::RST_STATUS;
    end else if (ce) begin
      if (rise) begin
        status_q <= 8'h01;
      end else if (act && dur_q >= amt_pkg::REPORT_START_TICKS) begin
        status_q <= dur_q;
      end else if (status_read) begin
        status_q[0] <= 1'b0;
      end
    end
  end

  // Limit event, once per assertion; a zero limit fires at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flagged_q <= 1'b0;
      timer_event_q <= 1'b0;
    end else if (ce) begin
      timer_event_q <= 1'b0;
      if (rise) begin
        flagged_q <= 1'b0;
      end
      if (act && (!flagged_q || rise) &&
          (duration_limit == 8'h00 ||
           (prev_q && dur_q > duration_limit))) begin
        flagged_q <= 1'b1;
        timer_event_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_rise;
    ce && act && !prev_q;
  endsequence

  property p_rise_flag;
    @(posedge aclk) disable iff (!aresetn)
      s_rise |=> status_q == 8'h01;
  endproperty
  a_rise_flag: assert property (p_rise_flag)
    else $error("assertion flag not set on overheat edge");

  property p_upper_zero;
    @(posedge aclk) disable iff (!aresetn)
      (ce && act && prev_q && dur_q < amt_pkg::REPORT_START_TICKS)
      |=> status_q[7:1] == 7'h00;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("duration bits nonzero before start time");

  property p_saturate;
    @(posedge aclk) disable iff (!aresetn)
      (dur_q == amt_pkg::COUNT_FULL && !rise) |=> dur_q == amt_pkg::COUNT_FULL;
  endproperty
  a_saturate: assert property (p_saturate)
    else $error("duration count wrapped");

  property p_limit_zero;
    @(posedge aclk) disable iff (!aresetn)
      s_rise ##0 (duration_limit == 8'h00) |=> timer_event_q;
  endproperty
  a_limit_zero: assert property (p_limit_zero)
    else $error("zero limit did not flag at assertion");
endmodule

// ===== rtl/amt_regs.sv
// Alert mask, low-bit readings, pin config and overheat timer registers
`timescale 1ns/1ps
module amt_regs #(
  parameter int ADDR_W = 12,
  parameter int TICK_CYC = amt_pkg::TICK_CYCLES
) (
  // Clock, reset, enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address and data
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Conversion results
  input wire logic meas_update,
  input wire amt_pkg::amt_meas_t meas,
  // Fault events and pins
  input wire logic [3:0] fan_fault,
  input wire logic [1:0] diode_fault,
  input wire logic speed_pulse_input_four_is_overheat,
  input wire logic overheat_in_n,
  input wire logic config_lock,
  input wire logic fan_two_pwm,
  // Outputs
  output logic pwm_two_pin,
  output logic fans_full_speed,
  output logic fast_speed_rate,
  output logic [3:0] continuous_speed,
  output logic irq
);
  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  logic [7:0] mask_one_q;
  logic [7:0] mask_two_q;
  logic [7:0] volt_rsv_q;
  logic [7:0] temp_rsv_q;
  logic [7:0] limit_q;
  logic [7:0] ev_stat_q;
  logic [7:0] ev_en_q;
  amt_pkg::amt_cfg_t cfg_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_full_q;
  logic w_full_q;
  logic do_wr;
  logic [7:0] wr_idx;
  logic [7:0] rd_idx;
  logic rd_hs;
  logic wr_lane;
  logic [9:0] rd_arr [amt_pkg::NUM_READINGS];
  logic [7:0] hi_q [amt_pkg::NUM_READINGS];
  logic [1:0] lo_q [amt_pkg::NUM_READINGS];
  logic [amt_pkg::NUM_READINGS-1:0] pend_q;
  logic volt_frozen;
  logic temp_frozen;
  logic overheat_act;
  logic status_read;
  logic [7:0] ot_status;
  logic timer_event;
  logic [7:0] ev_in;
  logic alert_now;

  // Index decode: upper address bits must be zero
  function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
    reg_idx = (a[ADDR_W-1:10] == '0) ? a[9:2] : 8'hff;
  endfunction

  // Which indices answer OKAY
  function automatic logic is_mapped(input logic [7:0] i);
    is_mapped = (i >= amt_pkg::IDX_ALERT_MASK_ONE &&
                 i <= amt_pkg::IDX_ASSERT_DURATION_LIMIT) ||
                (i >= amt_pkg::IDX_EVENT_STATUS &&
                 i < amt_pkg::IDX_HIGH_BYTE_BASE + 8'(amt_pkg::NUM_READINGS));
  endfunction

  assign wr_idx = reg_idx(awaddr_q);
  assign rd_idx = reg_idx(s_axi_araddr);
  assign do_wr = aw_full_q & w_full_q & ~s_axi_bvalid;
  assign wr_lane = do_wr & wstrb_q[0];
  assign rd_hs = s_axi_arvalid & s_axi_arready;
  assign status_read = rd_hs &&
                       rd_idx == amt_pkg::IDX_OVERHEAT_DURATION_STATUS;

  // ---------------------------------------------------------------
  // AXI4-Lite write channel: address and data in either order
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= amt_pkg::RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_q <= 1'b1;
        s_axi_awready <= 1'b0;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_q <= 1'b1;
        s_axi_wready <= 1'b0;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full_q <= 1'b0;
        w_full_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wr_idx) ? amt_pkg::RESP_OKAY :
                       amt_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Software-written registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_one_q <= amt_pkg::RST_MASK;
      mask_two_q <= amt_pkg::RST_MASK;
      volt_rsv_q <= 8'h00;
      temp_rsv_q <= 8'h00;
      limit_q <= amt_pkg::RST_LIMIT;
      ev_en_q <= 8'h00;
    end else if (ce && wr_lane) begin
      case (wr_idx)
        amt_pkg::IDX_ALERT_MASK_ONE: begin
          mask_one_q <= wdata_q[7:0];
        end
        amt_pkg::IDX_ALERT_MASK_TWO: begin
          // Bit 1 is read-only and stays clear
          mask_two_q <= wdata_q[7:0] & amt_pkg::MASK_TWO_WRITABLE;
        end
        amt_pkg::IDX_VOLTAGE_LOW_BITS: begin
          volt_rsv_q <= wdata_q[7:0] & amt_pkg::VOLT_RSV_BITS;
        end
        amt_pkg::IDX_TEMPERATURE_LOW_BITS: begin
          temp_rsv_q <= wdata_q[7:0] & amt_pkg::TEMP_RSV_BITS;
        end
        amt_pkg::IDX_ASSERT_DURATION_LIMIT: begin
          limit_q <= wdata_q[7:0];
        end
        amt_pkg::IDX_EVENT_ENABLE: begin
          ev_en_q <= wdata_q[7:0];
        end
        default: begin
        end
      endcase
    end
  end

  // Pin and speed config; the lock turns writes into no-ops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= amt_pkg::amt_cfg_t'(amt_pkg::RST_CONFIG);
    end else if (ce && wr_lane && !config_lock &&
                 wr_idx == amt_pkg::IDX_PIN_AND_SPEED_CONFIG) begin
      cfg_q <= amt_pkg::amt_cfg_t'(wdata_q[7:0]);
    end
  end

  // ---------------------------------------------------------------
  // Reading snapshots with coherent freeze
  // ---------------------------------------------------------------
  assign rd_arr[0] = meas.ref_two_five;
  assign rd_arr[1] = meas.supply;
  assign rd_arr[2] = meas.remote_one;
  assign rd_arr[3] = meas.local_temp;
  assign rd_arr[4] = meas.remote_two;
  // A low-bit read also blocks an update landing on its own edge
  assign volt_frozen = |pend_q[1:0] |
                       (rd_hs && rd_idx == amt_pkg::IDX_VOLTAGE_LOW_BITS);
  assign temp_frozen = |pend_q[4:2] |
                       (rd_hs &&
                        rd_idx == amt_pkg::IDX_TEMPERATURE_LOW_BITS);

  // Low-bit read arms its group; each high-byte read releases one
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_q <= '0;
    end else if (ce && rd_hs) begin
      if (rd_idx == amt_pkg::IDX_VOLTAGE_LOW_BITS) begin
        pend_q[1:0] <= 2'b11;
      end else if (rd_idx == amt_pkg::IDX_TEMPERATURE_LOW_BITS) begin
        pend_q[4:2] <= 3'b111;
      end else if (rd_idx >= amt_pkg::IDX_HIGH_BYTE_BASE &&
                   rd_idx < amt_pkg::IDX_HIGH_BYTE_BASE +
                   8'(amt_pkg::NUM_READINGS)) begin
        pend_q[3'(rd_idx - amt_pkg::IDX_HIGH_BYTE_BASE)] <= 1'b0;
      end
    end
  end

  // Snapshots update only while their group is not frozen
  for (genvar g = 0; g < amt_pkg::NUM_READINGS; g++) begin : g_snap
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        hi_q[g] <= 8'h00;
        lo_q[g] <= 2'b00;
      end else if (ce && meas_update &&
                   !(g < 2 ? volt_frozen : temp_frozen)) begin
        hi_q[g] <= rd_arr[g][9:2];
        lo_q[g] <= rd_arr[g][1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // Overheat timer and pin outputs
  // ---------------------------------------------------------------
  assign overheat_act = ~overheat_in_n & speed_pulse_input_four_is_overheat;

  amt_overheat_timer #(
    .TICK_CYC(TICK_CYC)
  ) u_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .monitor_en(cfg_q.overheat_monitor_en),
    .overheat_active(overheat_act),
    .duration_limit(limit_q),
    .status_read(status_read),
    .status_q(ot_status),
    .timer_event_q(timer_event)
  );

  // Sticky events share the second mask layout
  assign ev_in = {diode_fault,
                  speed_pulse_input_four_is_overheat ?
                    timer_event : fan_fault[3],
                  fan_fault[2:0], 2'b00};

  // Set wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_stat_q <= 8'h00;
    end else if (ce) begin
      if (wr_lane && wr_idx == amt_pkg::IDX_EVENT_CLEAR) begin
        ev_stat_q <= (ev_stat_q & ~wdata_q[7:0]) | ev_in;
      end else begin
        ev_stat_q <= ev_stat_q | ev_in;
      end
    end
  end

  // Unmasked fan, diode and overheat timer events drive the alert
  assign alert_now = |(ev_stat_q & ~mask_two_q &
                       amt_pkg::ALERT_SOURCES);

  // Registered pins; alert is active low on the shared pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_two_pin <= 1'b0;
      fans_full_speed <= 1'b0;
      fast_speed_rate <= 1'b0;
      continuous_speed <= 4'h0;
      irq <= 1'b0;
    end else if (ce) begin
      pwm_two_pin <= cfg_q.alert_pin_sel ? ~alert_now : fan_two_pwm;
      fans_full_speed <= cfg_q.full_speed_on_overheat &
                         cfg_q.overheat_monitor_en & overheat_act;
      fast_speed_rate <= cfg_q.fast_speed_rate;
      continuous_speed <= {cfg_q.continuous_speed_four,
                           cfg_q.continuous_speed_three,
                           cfg_q.continuous_speed_two,
                           cfg_q.continuous_speed_one};
      irq <= |(ev_stat_q & ev_en_q);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel, data registered at the handshake
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= amt_pkg::RESP_OKAY;
    end else if (ce) begin
      if (rd_hs) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= is_mapped(rd_idx) ? amt_pkg::RESP_OKAY :
                       amt_pkg::RESP_SLVERR;
        s_axi_rdata <= 32'h0;
        case (rd_idx)
          amt_pkg::IDX_ALERT_MASK_ONE: s_axi_rdata[7:0] <= mask_one_q;
          amt_pkg::IDX_ALERT_MASK_TWO: s_axi_rdata[7:0] <= mask_two_q;
          amt_pkg::IDX_VOLTAGE_LOW_BITS: begin
            s_axi_rdata[7:0] <= volt_rsv_q |
              {2'b00, lo_q[1], 2'b00, lo_q[0]};
          end
          amt_pkg::IDX_TEMPERATURE_LOW_BITS: begin
            s_axi_rdata[7:0] <= temp_rsv_q |
              {lo_q[4], lo_q[3], lo_q[2], 2'b00};
          end
          amt_pkg::IDX_PIN_AND_SPEED_CONFIG: s_axi_rdata[7:0] <= cfg_q;
          amt_pkg::IDX_OVERHEAT_DURATION_STATUS: begin
            s_axi_rdata[7:0] <= ot_status;
          end
          amt_pkg::IDX_ASSERT_DURATION_LIMIT: s_axi_rdata[7:0] <= limit_q;
          amt_pkg::IDX_EVENT_STATUS: s_axi_rdata[7:0] <= ev_stat_q;
          amt_pkg::IDX_EVENT_ENABLE: s_axi_rdata[7:0] <= ev_en_q;
          default: begin
            if (rd_idx >= amt_pkg::IDX_HIGH_BYTE_BASE &&
                rd_idx < amt_pkg::IDX_HIGH_BYTE_BASE +
                8'(amt_pkg::NUM_READINGS)) begin
              s_axi_rdata[7:0] <=
                hi_q[3'(rd_idx - amt_pkg::IDX_HIGH_BYTE_BASE)];
            end
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_mask_quiet;
    @(posedge aclk) disable iff (!aresetn)
      (ce && cfg_q.alert_pin_sel && ev_stat_q[4:2] != 3'b000 &&
       (ev_stat_q[4:2] & ~mask_two_q[4:2]) == 3'b000 &&
       (ev_stat_q[7:5] & ~mask_two_q[7:5]) == 3'b000) |=> pwm_two_pin;
  endproperty
  a_mask_quiet: assert property (p_mask_quiet)
    else $error("masked fan fault still drove the alert");

  property p_diode_alert;
    @(posedge aclk) disable iff (!aresetn)
      (ce && cfg_q.alert_pin_sel && ev_stat_q[amt_pkg::BIT_DIODE_ONE] &&
       !mask_two_q[amt_pkg::BIT_DIODE_ONE]) |=> !pwm_two_pin;
  endproperty
  a_diode_alert: assert property (p_diode_alert)
    else $error("unmasked diode fault gave no alert");

  property p_lock;
    @(posedge aclk) disable iff (!aresetn)
      (config_lock && do_wr) |=> $stable(cfg_q);
  endproperty
  a_lock: assert property (p_lock)
    else $error("locked config register changed");

  sequence s_volt_armed;
    volt_frozen && ce && meas_update;
  endsequence

  property p_freeze;
    @(posedge aclk) disable iff (!aresetn)
      s_volt_armed |=> $stable(lo_q[0]) && $stable(hi_q[0]);
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("frozen reading changed");

  property p_full_speed_on_overheat;
    @(posedge aclk) disable iff (!aresetn)
      (ce && cfg_q.full_speed_on_overheat && cfg_q.overheat_monitor_en &&
       overheat_act) |=> fans_full_speed;
  endproperty
  a_full_speed_on_overheat: assert property (p_full_speed_on_overheat)
    else $error("overheat did not force full fan speed");

  property p_cont;
    @(posedge aclk) disable iff (!aresetn)
      ce |=> continuous_speed == $past(cfg_q[7:4]);
  endproperty
  a_cont: assert property (p_cont)
    else $error("continuous speed outputs differ from config");
endmodule

// ===== bench/amt_overheat_src.sv
// Overheat source model for the active-low overheat pin
`timescale 1ns/1ps
module amt_overheat_src (
  // Clock
  input wire logic aclk,
  // Request: hold the pin low for len cycles
  input wire logic go,
  input wire logic [15:0] len,
  // Pin
  output logic overheat_in_n
);
  logic [15:0] left_q = 16'h0;
  // Count down; the pin is low while cycles remain
  always @(posedge aclk) begin
    if (go) left_q <= len;
    else if (left_q != 16'h0) left_q <= left_q - 16'h1;
  end
  assign overheat_in_n = (left_q == 16'h0);
endmodule

// ===== bench/amt_regs_bench.sv
// Register bench: bus tasks and directed checks
`timescale 1ns/1ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin \
  miscompares++; $display("wrong value %s exp %h got %h", n, e, s); end end
module amt_regs_bench;
  logic aclk = 0, aresetn = 0, ce = 1, go = 0, overheat_in_n;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0;
  logic s_axi_bready = 1, s_axi_rready = 1, meas_update = 0;
  logic speed_pulse_input_four_is_overheat = 1, config_lock = 0;
  logic fan_two_pwm = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, pwm_two_pin, fans_full_speed;
  logic fast_speed_rate, irq;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_q;
  logic [3:0] s_axi_wstrb = 4'hf, fan_fault = '0, continuous_speed;
  logic [1:0] diode_fault = '0, s_axi_bresp, s_axi_rresp, rs_q;
  logic [15:0] len = '0;
  logic [7:0] regs [5] = '{8'h74, 8'h75, 8'h78, 8'h79, 8'h7a};
  amt_pkg::amt_meas_t meas = '0;
  int miscompares = 0, compares = 0;

  // Short tick keeps the duration counts within a brief run
  amt_regs #(.TICK_CYC(10)) dut (.*);
  amt_overheat_src src (.*);

  always #4 aclk = ~aclk;

  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  task summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Address and data released one by one as each is taken
  task wr(input logic [7:0] i, input logic [7:0] d);
    logic a, w;
    a = 0;
    w = 0;
    s_axi_awaddr <= {2'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(a && w)) begin
      @(posedge aclk);
      if (s_axi_awready) a = 1;
      if (s_axi_wready) w = 1;
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    rs_q = s_axi_bresp;
  endtask
  task rd(input logic [7:0] i);
    s_axi_araddr <= {2'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd_q = s_axi_rdata;
    rs_q = s_axi_rresp;
  endtask
  task rc(input logic [7:0] i, input logic [7:0] e);
    rd(i);
    `CHK("rdata", {24'h0, e}, rd_q)
    `CHK("rresp", amt_pkg::RESP_OKAY, rs_q)
  endtask
  task cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task heat(input logic [15:0] n);
    len <= n;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask
  task upd(input amt_pkg::amt_meas_t v);
    meas <= v;
    meas_update <= 1'b1;
    @(posedge aclk);
    meas_update <= 1'b0;
  endtask

  // Hang guard, far beyond the few thousand cycles needed
  initial begin
    cyc(20000);
    miscompares++;
    summarize();
  end

  // ----------------------------------------------------------------
  // Directed sequence
  // ----------------------------------------------------------------
  initial begin
    cyc(2);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (regs[k]) rc(regs[k], 8'h00);
    rd(8'h10);
    `CHK("slverr", amt_pkg::RESP_SLVERR, rs_q)
    wr(8'h10, 8'h00);
    `CHK("bresp", amt_pkg::RESP_SLVERR, rs_q)
    wr(8'h75, 8'hff);
    `CHK("bresp", amt_pkg::RESP_OKAY, rs_q)
    rc(8'h75, 8'hfd);
    wr(8'h75, 8'h00);
    upd({10'h002, 10'h001, 10'h003, 10'h002, 10'h101});
    rc(8'h76, 8'h21);
    rc(8'h77, 8'h9c);
    upd('0);
    rc(8'h76, 8'h21);
    rc(8'h83, 8'h40);
    rc(8'h84, 8'h00);
    upd('0);
    rc(8'h76, 8'h00);
    wr(8'h7a, 8'h02);
    wr(8'h82, 8'h20);
    wr(8'h78, 8'h07);
    heat(16'd5);
    cyc(10);
    rc(8'h79, 8'h01);
    rc(8'h79, 8'h00);
    `CHK("irq", 1'b0, irq)
    heat(16'd55);
    cyc(4);
    `CHK("full_speed_on_overheat", 1'b1, fans_full_speed)
    cyc(60);
    `CHK("irq", 1'b1, irq)
    `CHK("alert", 1'b0, pwm_two_pin)
    rc(8'h79, 8'h05);
    rc(8'h79, 8'h04);
    rc(8'h80, 8'h20);
    wr(8'h75, 8'h20);
    cyc(2);
    `CHK("masked", 1'b1, pwm_two_pin)
    wr(8'h81, 8'h20);
    cyc(2);
    `CHK("irq", 1'b0, irq)
    heat(16'd2600);
    cyc(2610);
    rc(8'h79, 8'hff);
    // Masked fan fault stays quiet; a fault while ce is low is lost
    wr(8'h75, 8'h3c);
    fan_fault <= 4'h1;
    cyc(1);
    ce <= 1'b0;
    fan_fault <= 4'h2;
    cyc(1);
    ce <= 1'b1;
    fan_fault <= 4'h0;
    cyc(2);
    `CHK("fanmask", 1'b1, pwm_two_pin)
    rc(8'h80, 8'h24);
    diode_fault <= 2'h1;
    cyc(1);
    diode_fault <= 2'h0;
    cyc(2);
    `CHK("diode", 1'b0, pwm_two_pin)
    // Zero limit flags at the assertion edge
    wr(8'h81, 8'hff);
    wr(8'h7a, 8'h00);
    heat(16'd3);
    cyc(4);
    rc(8'h80, 8'h20);
    rc(8'h79, 8'h01);
    wr(8'h78, 8'hf8);
    fan_two_pwm <= 1'b0;
    cyc(2);
    `CHK("pwm", 1'b0, pwm_two_pin)
    `CHK("fast", 1'b1, fast_speed_rate)
    `CHK("cont", 4'hf, continuous_speed)
    heat(16'd5);
    cyc(8);
    rc(8'h79, 8'h00);
    config_lock <= 1'b1;
    wr(8'h78, 8'h00);
    rc(8'h78, 8'hf8);
    summarize();
  end
endmodule
